// ===== hdl/tmd_pkg.sv
// shared constants and types of the tap and motion sleep detector
package tmd_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_TAP_THRESHOLD   = 8'h1D;
	localparam logic [7:0] IDX_TAP_DURATION    = 8'h21;
	localparam logic [7:0] IDX_TAP_GAP         = 8'h22;
	localparam logic [7:0] IDX_SECOND_TAP      = 8'h23;
	localparam logic [7:0] IDX_ACT_THRESHOLD   = 8'h24;
	localparam logic [7:0] IDX_INACT_THRESHOLD = 8'h25;
	localparam logic [7:0] IDX_INACT_TIME      = 8'h26;
	localparam logic [7:0] IDX_TAP_AXIS_CTRL   = 8'h2A;
	localparam logic [7:0] IDX_AXIS_STATUS     = 8'h2B;
	localparam logic [7:0] IDX_MOTION_CTRL     = 8'h2D;
	localparam logic [7:0] IDX_INT_ENABLE      = 8'h2E;
	localparam logic [7:0] IDX_EVENT_SOURCE    = 8'h30;
	localparam logic [7:0] REG_RESET           = 8'h00;

	// event bits, shared by enable mask and source flags
	localparam int BIT_SINGLE_TAP = 6;
	localparam int BIT_DOUBLE_TAP = 5;
	localparam int BIT_ACTIVITY   = 4;
	localparam int BIT_INACTIVITY = 3;
	// tap axis control bits; axis enables sit in bits 2..0 (x,y,z)
	localparam int BIT_SUPPRESS   = 3;
	// status: activity axes 6..4, asleep 3, tap axes 2..0
	localparam int ACT_AXIS_LSB   = 4;
	localparam int BIT_ASLEEP     = 3;
	// motion control bits
	localparam int BIT_LINK       = 5;
	localparam int BIT_AUTO_SLEEP = 4;
	localparam int BIT_SLEEP      = 3;

	// timing in ns, sample counts derived
	localparam longint SAMPLE_NS    = 312500;
	localparam longint DUR_LSB_NS   = 625000;
	localparam longint GAP_LSB_NS   = 1250000;
	localparam longint WIN_LSB_NS   = 1250000;
	localparam longint INACT_LSB_NS = 1000000000;
	localparam int DUR_SAMPLES   = int'(DUR_LSB_NS / SAMPLE_NS);
	localparam int GAP_SAMPLES   = int'(GAP_LSB_NS / SAMPLE_NS);
	localparam int WIN_SAMPLES   = int'(WIN_LSB_NS / SAMPLE_NS);
	localparam int INACT_SAMPLES = int'(INACT_LSB_NS / SAMPLE_NS);
	// threshold LSB is 16 sample LSBs
	localparam int THRESH_SHIFT  = 4;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic               valid;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} tmd_sample_s;

	typedef enum logic [2:0] {
		TAP_IDLE,
		TAP_FIRST,
		TAP_GAP,
		TAP_WINDOW,
		TAP_SECOND,
		TAP_WAIT_LOW
	} tmd_tap_e;
endpackage

// ===== hdl/tmd_detector.sv
// tap detector, activity/inactivity link and auto sleep with AXI4-Lite registers
`timescale 1ns/1ps
// Summary of operation
// - axis above threshold register starts tap
// - duration register limits tap length
// - latency wait after first tap ends
// - window opens after latency expires
// - second tap must start inside window
// - single only: report on falling below
// - both enabled: single waits double outcome
// - suppress: spike during latency cancels double
// - above threshold at window open invalidates
// - overlong second tap invalidates at limit
// - single and double enabled separately
// - per-axis enable bits gate tap
// - double needs nonzero latency and window
// - first tap axis latched, never cleared
// - detection runs on undecimated samples
// - link: activity sought only after inactivity
// - source read clears pending events
// - uncleared activity blocks auto sleep
// - asleep bit shows sleep state
// - inactivity enters sleep, arms activity
// - activity wakes, rearms inactivity
module tmd_detector #(
	parameter int INACT_LSB_SAMPLES = tmd_pkg::INACT_SAMPLES
) (
	input  wire logic               mclk,
	input  wire logic               rstn,
	input  wire tmd_pkg::tmd_sample_s sample,
	input  wire logic [11:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [11:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic                    lowRate
);
	import tmd_pkg::*;
	logic [7:0]  thrTap_q, durTap_q, gapTap_q, winTap_q;
	logic [7:0]  thrAct_q, thrInact_q, timeInact_q;
	logic [7:0]  axisCtrl_q, motionCtrl_q, intEnable_q, source_q, status_q;
	logic [11:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        awHave_q, wHave_q;
	logic        awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
	logic [1:0]  bResp_q, rResp_q;
	logic [31:0] rData_q;
	logic        asleep_q, actArmed_q, inactArmed_q;
	tmd_tap_e    tapSt_q;
	logic [10:0] tapCnt_q;
	logic [19:0] inactCnt_q;
	// bus decode
	wire        awTake    = s_axi_awvalid && awReady_q;
	wire        wTake     = s_axi_wvalid && wReady_q;
	wire        arTake    = s_axi_arvalid && arReady_q;
	wire [11:0] wAddr     = awHave_q ? awAddr_q : s_axi_awaddr;
	wire [31:0] wData     = wHave_q ? wData_q : s_axi_wdata;
	wire [3:0]  wStrb     = wHave_q ? wStrb_q : s_axi_wstrb;
	wire        wAddrOk   = (wAddr[1:0] == 2'h0) && (wAddr[11:10] == 2'h0);
	wire [7:0]  wIdx      = wAddr[9:2];
	wire        doWrite   = (awHave_q || awTake) && (wHave_q || wTake) && !bValid_q;
	wire        wrEn      = doWrite && wAddrOk && wStrb[0];
	wire        wrKnown   = (wIdx == IDX_TAP_THRESHOLD) || (wIdx == IDX_TAP_DURATION)
		|| (wIdx == IDX_TAP_GAP) || (wIdx == IDX_SECOND_TAP) || (wIdx == IDX_ACT_THRESHOLD)
		|| (wIdx == IDX_INACT_THRESHOLD) || (wIdx == IDX_INACT_TIME)
		|| (wIdx == IDX_TAP_AXIS_CTRL) || (wIdx == IDX_MOTION_CTRL)
		|| (wIdx == IDX_INT_ENABLE);
	wire        rAddrOk   = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[11:10] == 2'h0);
	wire [7:0]  rIdx      = s_axi_araddr[9:2];
	logic [7:0] rMux;
	logic       rKnown;
	always_comb begin
		rKnown = rAddrOk;
		case (rIdx)
			IDX_TAP_THRESHOLD:   rMux = thrTap_q;
			IDX_TAP_DURATION:    rMux = durTap_q;
			IDX_TAP_GAP:         rMux = gapTap_q;
			IDX_SECOND_TAP:      rMux = winTap_q;
			IDX_ACT_THRESHOLD:   rMux = thrAct_q;
			IDX_INACT_THRESHOLD: rMux = thrInact_q;
			IDX_INACT_TIME:      rMux = timeInact_q;
			IDX_TAP_AXIS_CTRL:   rMux = axisCtrl_q;
			IDX_AXIS_STATUS:     rMux = status_q;
			IDX_MOTION_CTRL:     rMux = motionCtrl_q;
			IDX_INT_ENABLE:      rMux = intEnable_q;
			IDX_EVENT_SOURCE:    rMux = source_q;
			default: begin
				rMux   = 8'h00;
				rKnown = 1'b0;
			end
		endcase
	end
	wire srcRead = arTake && rAddrOk && (rIdx == IDX_EVENT_SOURCE);
	// per-axis magnitude compare on undecimated samples
	wire signed [15:0] axVal [3];
	assign axVal[0] = sample.x;
	assign axVal[1] = sample.y;
	assign axVal[2] = sample.z;
	logic [2:0] tapAbove, actAbove, inactAbove;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gAxis
			wire [15:0] mag = axVal[g][15] ? 16'(-axVal[g]) : 16'(axVal[g]);
			// bit 2 of each field is x
			assign tapAbove[2-g]   = axisCtrl_q[2-g]
				&& (mag > {4'h0, thrTap_q, 4'h0});
			assign actAbove[2-g]   = mag > {4'h0, thrAct_q, 4'h0};
			assign inactAbove[2-g] = mag > {4'h0, thrInact_q, 4'h0};
		end
	endgenerate
	wire anyTap   = |tapAbove;
	wire smp      = sample.valid;
	// timer limits in samples
	wire [10:0] durLim = 11'(durTap_q) * 11'(DUR_SAMPLES);
	wire [10:0] gapLim = 11'(gapTap_q) * 11'(GAP_SAMPLES);
	wire [10:0] winLim = 11'(winTap_q) * 11'(WIN_SAMPLES);
	wire        enSingle = intEnable_q[BIT_SINGLE_TAP];
	wire        enDouble = intEnable_q[BIT_DOUBLE_TAP]
		&& (gapTap_q != 8'h00) && (winTap_q != 8'h00);
	wire        suppress = axisCtrl_q[BIT_SUPPRESS];
	// tap sequencer
	tmd_tap_e    tapSt_d;
	logic [10:0] tapCnt_d;
	logic        firstTap, singleHit, doubleHit;
	always_comb begin
		tapSt_d   = tapSt_q;
		tapCnt_d  = tapCnt_q;
		firstTap  = 1'b0;
		singleHit = 1'b0;
		doubleHit = 1'b0;
		if (smp) begin
			case (tapSt_q)
				TAP_IDLE: if (anyTap) begin
					tapSt_d  = TAP_FIRST;
					tapCnt_d = 11'h001;
					firstTap = 1'b1;
				end
				TAP_FIRST: if (anyTap) begin
					if (tapCnt_q >= durLim) begin
						tapSt_d = TAP_WAIT_LOW;
					end else begin
						tapCnt_d = tapCnt_q + 11'h001;
					end
				end else if (enDouble) begin
					tapSt_d  = TAP_GAP;
					tapCnt_d = 11'h001;
				end else begin
					singleHit = 1'b1;
					tapSt_d   = TAP_IDLE;
				end
				TAP_GAP: if (suppress && anyTap) begin
					singleHit = 1'b1;
					tapSt_d   = TAP_WAIT_LOW;
				end else if (tapCnt_q >= gapLim) begin
					if (anyTap) begin
						singleHit = 1'b1;
						tapSt_d   = TAP_WAIT_LOW;
					end else begin
						tapSt_d  = TAP_WINDOW;
						tapCnt_d = 11'h001;
					end
				end else begin
					tapCnt_d = tapCnt_q + 11'h001;
				end
				TAP_WINDOW: if (anyTap) begin
					tapSt_d  = TAP_SECOND;
					tapCnt_d = 11'h001;
				end else if (tapCnt_q >= winLim) begin
					singleHit = 1'b1;
					tapSt_d   = TAP_IDLE;
				end else begin
					tapCnt_d = tapCnt_q + 11'h001;
				end
				TAP_SECOND: if (anyTap) begin
					if (tapCnt_q >= durLim) begin
						singleHit = 1'b1;
						tapSt_d   = TAP_WAIT_LOW;
					end else begin
						tapCnt_d = tapCnt_q + 11'h001;
					end
				end else begin
					singleHit = 1'b1;
					doubleHit = 1'b1;
					tapSt_d   = TAP_IDLE;
				end
				TAP_WAIT_LOW: if (!anyTap) begin
					tapSt_d = TAP_IDLE;
				end
				default: tapSt_d = TAP_IDLE;
			endcase
		end
	end
	// activity/inactivity; with link, activity waits for an inactivity first
	wire linkOn    = motionCtrl_q[BIT_LINK];
	wire autoSleep = motionCtrl_q[BIT_SLEEP] && motionCtrl_q[BIT_AUTO_SLEEP] && linkOn;
	wire actHit    = smp && (actArmed_q || !linkOn) && intEnable_q[BIT_ACTIVITY] && (|actAbove);
	wire [19:0] inactLim = 20'(timeInact_q) * 20'(INACT_LSB_SAMPLES);
	wire quiet     = !(|inactAbove);
	wire inactHit  = smp && inactArmed_q && intEnable_q[BIT_INACTIVITY] && quiet
		&& (inactCnt_q + 20'h00001 >= inactLim);
	// a still-pending activity flag holds the part awake
	wire goSleep   = inactHit && autoSleep && !source_q[BIT_ACTIVITY];
	logic [7:0] srcSet;
	always_comb begin
		srcSet                 = 8'h00;
		srcSet[BIT_SINGLE_TAP] = singleHit && enSingle;
		srcSet[BIT_DOUBLE_TAP] = doubleHit && intEnable_q[BIT_DOUBLE_TAP];
		srcSet[BIT_ACTIVITY]   = actHit;
		srcSet[BIT_INACTIVITY] = inactHit;
	end
	// set wins over a clearing read in the same cycle
	wire [7:0] source_d = (srcRead ? 8'h00 : source_q) | srcSet;
	logic [2:0] tapAxes_q;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tapSt_q      <= TAP_IDLE;
			tapCnt_q     <= 11'h000;
			tapAxes_q    <= 3'h0;
			status_q     <= REG_RESET;
			source_q     <= REG_RESET;
			asleep_q     <= 1'b0;
			lowRate      <= 1'b0;
			actArmed_q   <= 1'b0;
			inactArmed_q <= 1'b1;
			inactCnt_q   <= 20'h00000;
		end else begin
			tapSt_q  <= tapSt_d;
			tapCnt_q <= tapCnt_d;
			source_q <= source_d;
			if (firstTap) begin
				tapAxes_q <= tapAbove;
			end
			if (srcSet[BIT_SINGLE_TAP] || srcSet[BIT_DOUBLE_TAP]) begin
				status_q[2:0] <= tapAxes_q;
			end
			if (actHit) begin
				status_q[ACT_AXIS_LSB +: 3] <= actAbove;
			end
			status_q[BIT_ASLEEP] <= goSleep ? 1'b1 : (actHit ? 1'b0 : asleep_q);
			if (smp) begin
				inactCnt_q <= (quiet && !inactHit) ? inactCnt_q + 20'h00001 : 20'h00000;
			end
			if (goSleep) begin
				asleep_q <= 1'b1;
				lowRate  <= 1'b1;
			end else if (actHit) begin
				asleep_q <= 1'b0;
				lowRate  <= 1'b0;
			end
			if (!linkOn) begin
				actArmed_q   <= 1'b0;
				inactArmed_q <= 1'b1;
			end else if (inactHit) begin
				inactArmed_q <= 1'b0;
				actArmed_q   <= 1'b1;
			end else if (actHit) begin
				actArmed_q   <= 1'b0;
				inactArmed_q <= 1'b1;
			end
		end
	end
	// register writes; any value is taken, tuning is left to the host
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			thrTap_q     <= REG_RESET;
			durTap_q     <= REG_RESET;
			gapTap_q     <= REG_RESET;
			winTap_q     <= REG_RESET;
			thrAct_q     <= REG_RESET;
			thrInact_q   <= REG_RESET;
			timeInact_q  <= REG_RESET;
			axisCtrl_q   <= REG_RESET;
			motionCtrl_q <= REG_RESET;
			intEnable_q  <= REG_RESET;
		end else if (wrEn) begin
			case (wIdx)
				IDX_TAP_THRESHOLD:   thrTap_q     <= wData[7:0];
				IDX_TAP_DURATION:    durTap_q     <= wData[7:0];
				IDX_TAP_GAP:         gapTap_q     <= wData[7:0];
				IDX_SECOND_TAP:      winTap_q     <= wData[7:0];
				IDX_ACT_THRESHOLD:   thrAct_q     <= wData[7:0];
				IDX_INACT_THRESHOLD: thrInact_q   <= wData[7:0];
				IDX_INACT_TIME:      timeInact_q  <= wData[7:0];
				IDX_TAP_AXIS_CTRL:   axisCtrl_q   <= wData[7:0];
				IDX_MOTION_CTRL:     motionCtrl_q <= wData[7:0];
				IDX_INT_ENABLE:      intEnable_q  <= wData[7:0];
				default: ;
			endcase
		end
	end
	// write channel: address and data taken in either order
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			awHave_q  <= 1'b0;
			wHave_q   <= 1'b0;
			awReady_q <= 1'b1;
			wReady_q  <= 1'b1;
			bValid_q  <= 1'b0;
			bResp_q   <= RESP_OKAY;
			awAddr_q  <= 12'h000;
			wData_q   <= 32'h00000000;
			wStrb_q   <= 4'h0;
		end else if (doWrite) begin
			awHave_q  <= 1'b0;
			wHave_q   <= 1'b0;
			awReady_q <= 1'b0;
			wReady_q  <= 1'b0;
			bValid_q  <= 1'b1;
			bResp_q   <= (wAddrOk && wrKnown) ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (awTake) begin
				awHave_q  <= 1'b1;
				awAddr_q  <= s_axi_awaddr;
				awReady_q <= 1'b0;
			end
			if (wTake) begin
				wHave_q  <= 1'b1;
				wData_q  <= s_axi_wdata;
				wStrb_q  <= s_axi_wstrb;
				wReady_q <= 1'b0;
			end
			if (bValid_q && s_axi_bready) begin
				bValid_q  <= 1'b0;
				awReady_q <= 1'b1;
				wReady_q  <= 1'b1;
			end
		end
	end
	// read channel
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			arReady_q <= 1'b1;
			rValid_q  <= 1'b0;
			rData_q   <= 32'h00000000;
			rResp_q   <= RESP_OKAY;
		end else if (arTake) begin
			arReady_q <= 1'b0;
			rValid_q  <= 1'b1;
			rData_q   <= {24'h000000, rMux};
			rResp_q   <= rKnown ? RESP_OKAY : RESP_SLVERR;
		end else if (rValid_q && s_axi_rready) begin
			rValid_q  <= 1'b0;
			arReady_q <= 1'b1;
		end
	end
	assign s_axi_awready = awReady_q;
	assign s_axi_wready  = wReady_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_tap_start: assert property ((tapSt_q == TAP_IDLE) && smp && anyTap
		|=> tapSt_q == TAP_FIRST) else $error("tap start missed");
	a_dur_limit: assert property ((tapSt_q == TAP_FIRST) && smp && anyTap
		&& (tapCnt_q >= durLim) |=> tapSt_q == TAP_WAIT_LOW) else $error("overlong tap kept");
	a_single_only: assert property ((tapSt_q == TAP_FIRST) && smp && !anyTap
		&& !enDouble && enSingle |=> source_q[BIT_SINGLE_TAP]) else $error("single not flagged");
	a_no_double: assert property ((tapSt_q == TAP_FIRST) && smp && !anyTap
		&& ((gapTap_q == 8'h00) || (winTap_q == 8'h00)) |=> tapSt_q != TAP_GAP)
		else $error("double path with a zero timer");
	a_suppress_gap: assert property ((tapSt_q == TAP_GAP) && smp && suppress && anyTap
		|=> tapSt_q == TAP_WAIT_LOW && !$rose(source_q[BIT_DOUBLE_TAP]))
		else $error("suppress ignored");
	a_window_open: assert property ((tapSt_q == TAP_GAP) && smp && anyTap
		&& (tapCnt_q >= gapLim) |=> tapSt_q != TAP_WINDOW) else $error("window opened above");
	a_double_single: assert property ($rose(source_q[BIT_DOUBLE_TAP]) && enSingle
		|-> source_q[BIT_SINGLE_TAP]) else $error("single not with double");
	a_read_clear: assert property (srcRead && (srcSet == 8'h00)
		|=> source_q == 8'h00) else $error("source not cleared");
	a_sleep_block: assert property (source_q[BIT_ACTIVITY] |=> !$rose(asleep_q))
		else $error("sleep with activity pending");
	a_asleep_bit: assert property (status_q[BIT_ASLEEP] == asleep_q)
		else $error("asleep bit mismatch");
	a_wake_rate: assert property (actHit && asleep_q
		|=> !lowRate ##1 !lowRate || actHit) else $error("wake did not restore rate");
	a_link_arm: assert property (linkOn && inactHit && !actHit
		|=> !inactArmed_q && actArmed_q) else $error("link arming wrong");
endmodule

// ===== sim/tmd_host_model.sv
// AXI4-Lite master standing in for the host processor
`timescale 1ns/1ps
module tmd_host_model (
	input  wire logic        mclk,
	output logic [11:0]      s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [11:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		s_axi_awaddr = 12'h000;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 12'h000;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end

	// handshakes read at the rising edge, before the slave's flops update
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
		logic ta, tw, tb, got;
		got = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!got) begin
			@(posedge mclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			if (tb) resp = s_axi_bresp;
			// released payload scrambled so a stale value never looks valid
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~s_axi_awaddr;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~s_axi_wdata;
			end
			if (tb) begin
				s_axi_bready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
		logic ta, tb, got;
		got = 1'b0;
		@(posedge mclk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!got) begin
			@(posedge mclk);
			ta = s_axi_arvalid & s_axi_arready;
			tb = s_axi_rvalid;
			if (tb) d = s_axi_rdata;
			if (tb) resp = s_axi_rresp;
			if (ta) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~s_axi_araddr;
			end
			if (tb) begin
				s_axi_rready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask
endmodule

// ===== sim/tmd_detector_tb.sv
// self-checking bench for the tap and motion sleep detector
`timescale 1ns/1ps
module tmd_detector_tb;
	import tmd_pkg::*;
	logic               mclk = 1'b0;
	logic               rstn = 1'b0;
	tmd_sample_s        smp = '0;
	logic               lowRate;
	logic [11:0]        s_axi_awaddr, s_axi_araddr;
	logic [31:0]        s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp, resp;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic               s_axi_rvalid, s_axi_rready;
	logic signed [15:0] tapLvl = 16'sh0064;
	int                 nFail = 0;
	int                 totalChecks = 0;
	int                 cyc = 0;
	int                 axisSel = 0;
	logic [7:0]         rwIdx [6];

	always #50 mclk = ~mclk;

	// inactivity time LSB shrunk to 4 samples to keep the run short
	tmd_detector #(.INACT_LSB_SAMPLES(4)) dut (
		.mclk(mclk), .rstn(rstn), .sample(smp), .lowRate(lowRate),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	tmd_host_model host (
		.mclk(mclk),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	task automatic summarize();
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wchk(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		host.wr(idx, d, resp);
		chk({30'h0, resp}, {30'h0, er});
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
		host.rd(idx, rdat, resp);
		chk(rdat, {24'h0, ed});
		chk({30'h0, resp}, {30'h0, er});
	endtask

	// one sample every four clocks, on the selected axis only
	task automatic samp(input logic signed [15:0] v, input int n);
		repeat (n) begin
			repeat (3) @(posedge mclk);
			smp.valid <= 1'b1;
			smp.x <= (axisSel == 0) ? v : 16'sh0000;
			smp.y <= (axisSel == 1) ? v : 16'sh0000;
			smp.z <= (axisSel == 2) ? v : 16'sh0000;
			@(posedge mclk);
			smp.valid <= 1'b0;
		end
	endtask

	task automatic lr(input logic e);
		repeat (2) @(posedge mclk);
		chk({31'h0, lowRate}, {31'h0, e});
	endtask

	task automatic tapRun(input logic [7:0] ctrl, en, gap, input int h1, l1, h2, l2, h3,
		input logic [7:0] exp);
		wchk(IDX_TAP_AXIS_CTRL, ctrl, RESP_OKAY);
		wchk(IDX_INT_ENABLE, en, RESP_OKAY);
		wchk(IDX_TAP_GAP, gap, RESP_OKAY);
		samp(tapLvl, h1);
		samp(16'sh0000, l1);
		samp(tapLvl, h2);
		samp(16'sh0000, l2);
		samp(tapLvl, h3);
		samp(16'sh0000, 20);
		rchk(IDX_EVENT_SOURCE, exp, RESP_OKAY);
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			nFail++;
			summarize();
		end
	end

	initial begin
		rwIdx = '{IDX_TAP_THRESHOLD, IDX_TAP_DURATION, IDX_TAP_GAP, IDX_SECOND_TAP,
			IDX_TAP_AXIS_CTRL, IDX_INT_ENABLE};
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		foreach (rwIdx[i]) begin
			rchk(rwIdx[i], 8'h00, RESP_OKAY);
			wchk(rwIdx[i], rwIdx[i] ^ 8'hA5, RESP_OKAY);
			rchk(rwIdx[i], rwIdx[i] ^ 8'hA5, RESP_OKAY);
		end
		rchk(IDX_EVENT_SOURCE, 8'h00, RESP_OKAY);
		rchk(8'h27, 8'h00, RESP_SLVERR);
		wchk(IDX_TAP_DURATION, 8'h11, RESP_OKAY);
		rchk(IDX_TAP_DURATION, 8'h11, RESP_OKAY);
		wchk(IDX_AXIS_STATUS, 8'hFF, RESP_SLVERR);
		rchk(IDX_AXIS_STATUS, 8'h00, RESP_OKAY);
		wchk(IDX_TAP_THRESHOLD, 8'h02, RESP_OKAY);
		wchk(IDX_TAP_DURATION, 8'h02, RESP_OKAY);
		wchk(IDX_SECOND_TAP, 8'h02, RESP_OKAY);
		tapRun(8'h04, 8'h40, 8'h01, 2, 0, 0, 0, 0, 8'h40);
		rchk(IDX_AXIS_STATUS, 8'h04, RESP_OKAY);
		rchk(IDX_EVENT_SOURCE, 8'h00, RESP_OKAY);
		tapRun(8'h04, 8'h40, 8'h01, 6, 0, 0, 0, 0, 8'h00);
		axisSel = 1;
		tapRun(8'h04, 8'h40, 8'h01, 2, 0, 0, 0, 0, 8'h00);
		axisSel = 2;
		tapLvl = -16'sh0064;
		tapRun(8'h07, 8'h40, 8'h01, 2, 0, 0, 0, 0, 8'h40);
		rchk(IDX_AXIS_STATUS, 8'h01, RESP_OKAY);
		axisSel = 0;
		tapLvl = 16'sh0064;
		tapRun(8'h04, 8'h60, 8'h01, 2, 6, 2, 0, 0, 8'h60);
		tapRun(8'h04, 8'h20, 8'h01, 2, 6, 2, 0, 0, 8'h20);
		tapRun(8'h04, 8'h60, 8'h01, 2, 1, 2, 0, 0, 8'h40);
		tapRun(8'h04, 8'h60, 8'h01, 2, 1, 1, 4, 2, 8'h60);
		tapRun(8'h0C, 8'h60, 8'h01, 2, 1, 1, 4, 2, 8'h40);
		tapRun(8'h04, 8'h60, 8'h01, 2, 2, 4, 0, 0, 8'h40);
		tapRun(8'h04, 8'h60, 8'h01, 2, 6, 6, 0, 0, 8'h40);
		tapRun(8'h04, 8'h60, 8'h00, 2, 6, 2, 0, 0, 8'h40);
		wchk(IDX_TAP_GAP, 8'h01, RESP_OKAY);
		samp(tapLvl, 2);
		samp(16'sh0000, 2);
		rchk(IDX_EVENT_SOURCE, 8'h00, RESP_OKAY);
		samp(16'sh0000, 20);
		rchk(IDX_EVENT_SOURCE, 8'h40, RESP_OKAY);
		// motion part: taps off, one loud sample first to restart the quiet count
		wchk(IDX_INT_ENABLE, 8'h00, RESP_OKAY);
		wchk(IDX_ACT_THRESHOLD, 8'h02, RESP_OKAY);
		wchk(IDX_INACT_THRESHOLD, 8'h01, RESP_OKAY);
		wchk(IDX_INACT_TIME, 8'h01, RESP_OKAY);
		samp(tapLvl, 1);
		wchk(IDX_INT_ENABLE, 8'h18, RESP_OKAY);
		wchk(IDX_MOTION_CTRL, 8'h38, RESP_OKAY);
		samp(tapLvl, 1);
		rchk(IDX_EVENT_SOURCE, 8'h00, RESP_OKAY);
		samp(16'sh0000, 8);
		lr(1'b1);
		rchk(IDX_AXIS_STATUS, 8'h0C, RESP_OKAY);
		rchk(IDX_EVENT_SOURCE, 8'h08, RESP_OKAY);
		samp(16'sh0000, 8);
		rchk(IDX_EVENT_SOURCE, 8'h00, RESP_OKAY);
		samp(tapLvl, 1);
		samp(16'sh0000, 1);
		lr(1'b0);
		rchk(IDX_AXIS_STATUS, 8'h44, RESP_OKAY);
		samp(16'sh0000, 8);
		lr(1'b0);
		rchk(IDX_EVENT_SOURCE, 8'h18, RESP_OKAY);
		summarize();
	end
endmodule
